// ===== bench/ics_spi_host.sv
// SPI master model standing in for the host microcontroller
module ics_spi_host (
   // SPI pins
   output logic sclk,
   output logic chip_select_n,
   output logic sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] tx [16];
   logic [7:0] rx [16];

   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      sdi = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Host alone starts a transfer; clock idles low between frames
   // Select held for exactly nbits clocks, 8*(1+N) for N data bytes
   // Called at a falling reference edge; every step is a whole number of cycles
   task automatic xfer(input int nbits);
      chip_select_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi = tx[i/8][7-i%8];
         #200;
         sclk = 1'b1;
         rx[i/8][7-i%8] = sdo_oe_n ? 1'bx : sdo_out;
         #200;
         sclk = 1'b0;
      end
      #100;
      chip_select_n = 1'b1;
      // Released line must not look like the last bit
      sdi = ~sdi;
      #400;
   endtask
endmodule // ics_spi_host

// ===== bench/tb_top.sv
// Self-checking bench for the inductive sensor interface controller
`include "ics_map.svh"

module tb_top
   import ics_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic conv_done = 1'b0;
   ics_result_t conv_result = '0;
   logic sclk, chip_select_n, sdi, sdo_out, sdo_oe_n, conv_enable, interrupt_pin_n;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;

   always #25 ref_clk = ~ref_clk;

   ics_ctrl #(.REVISION(8'h3c), .SENSOR_PERIOD_NS(100)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .chip_select_n(chip_select_n),
      .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .conv_done(conv_done),
      .conv_result(conv_result), .conv_enable(conv_enable),
      .interrupt_pin_n(interrupt_pin_n));

   ics_spi_host i_host (
      .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
      .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic pin(input logic e);
      chk({7'h00, interrupt_pin_n}, {7'h00, e});
   endtask

   task automatic acc(input logic rd, input logic [6:0] a, input int cnt);
      i_host.tx[0] = {rd, a};
      i_host.xfer(8 * (1 + cnt));
      @(negedge ref_clk);
   endtask

   task automatic wr1(input logic [6:0] a, input logic [7:0] d);
      i_host.tx[1] = d;
      acc(1'b0, a, 1);
   endtask

   task automatic conv(input logic [7:0] p, input int w);
      conv_done = 1'b1;
      conv_result = {1'b0, p, 24'h12_3456};
      @(negedge ref_clk);
      conv_done = 1'b0;
      repeat (w) @(negedge ref_clk);
   endtask

   // Cycles within a short window where the pin shows level e
   task automatic cnt(input logic e, output int k);
      k = 0;
      repeat (12) begin
         @(posedge ref_clk);
         #1;
         if (interrupt_pin_n === e) k++;
      end
      @(negedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] exp [12] = '{8'h3c, 8'h0e, 8'h14, 8'h45, 8'h1b, 8'h01, 8'hff, 8'hff,
                               8'h00, 8'h00, 8'h00, 8'h00};
      chk({7'h00, conv_enable}, 8'h00);
      pin(1'b1);
      acc(1'b1, 7'h00, 12);
      for (int i = 0; i < 12; i++) chk(i_host.rx[i+1], exp[i]);
      $display("t_reset done");
   endtask

   task automatic t_write;
      wr1(7'h07, 8'h5a);
      acc(1'b1, 7'h07, 1);
      chk(i_host.rx[1], 8'h5a);
      i_host.tx[0] = 8'h07;
      i_host.tx[1] = 8'ha5;
      i_host.xfer(15);
      @(negedge ref_clk);
      acc(1'b1, 7'h07, 1);
      chk(i_host.rx[1], 8'h5a);
      $display("t_write done");
   endtask

   task automatic t_comp;
      i_host.tx[1] = 8'h80;
      i_host.tx[2] = 8'h00;
      i_host.tx[3] = 8'h40;
      acc(1'b0, 7'h07, 3);
      acc(1'b1, 7'h07, 3);
      chk(i_host.rx[3], 8'h40);
      wr1(7'h0a, 8'h02);
      conv(8'hf0, 3);
      pin(1'b1);
      wr1(7'h0b, 8'h01);
      chk({7'h00, conv_enable}, 8'h01);
      conv(8'h80, 3);
      pin(1'b1);
      conv(8'h81, 3);
      pin(1'b0);
      conv(8'h40, 3);
      pin(1'b0);
      conv(8'h3f, 3);
      pin(1'b1);
      conv(8'h90, 3);
      acc(1'b1, 7'h20, 1);
      chk(i_host.rx[1] & 8'h9f, 8'h10);
      wr1(7'h01, 8'h77);
      acc(1'b1, 7'h01, 1);
      chk(i_host.rx[1], 8'h0e);
      $display("t_comp done");
   endtask

   task automatic t_wake;
      wr1(7'h0a, 8'h01);
      conv(8'h30, 3);
      pin(1'b1);
      conv(8'h90, 3);
      pin(1'b0);
      conv(8'h30, 3);
      pin(1'b0);
      acc(1'b1, 7'h20, 1);
      chk(i_host.rx[1] & 8'hbf, 8'h20);
      wr1(7'h0a, 8'h00);
      pin(1'b1);
      conv(8'h90, 3);
      pin(1'b1);
      $display("t_wake done");
   endtask

   task automatic t_data_ready_mode;
      wr1(7'h0a, 8'h04);
      conv(8'h55, 3);
      pin(1'b0);
      chk({7'h00, chip_select_n}, 8'h01);
      acc(1'b1, 7'h20, 1);
      chk(i_host.rx[1] & 8'h4f, 8'h00);
      conv(8'h56, 0);
      cnt(1'b1, n);
      chk(n[7:0], 8'h02);
      pin(1'b0);
      acc(1'b1, 7'h22, 4);
      chk(i_host.rx[1], 8'h56);
      chk(i_host.rx[2], 8'h56);
      chk(i_host.rx[3], 8'h34);
      chk(i_host.rx[4], 8'h12);
      pin(1'b1);
      fork
         acc(1'b1, 7'h20, 1);
         begin
            repeat (40) @(negedge ref_clk);
            conv(8'h57, 0);
            cnt(1'b0, n);
            chk(n[7:0], 8'h02);
         end
      join
      pin(1'b1);
      $display("t_data_ready_mode done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("ERROR %0t ns: run did not finish in time", $time);
         test_done();
      end
   end

   initial begin
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_reset();
      t_write();
      t_comp();
      t_wake();
      t_data_ready_mode();
      test_done();
   end
endmodule // tb_top

// ===== hdl/ics_ctrl.sv
// Inductive sensor interface controller: SPI slave, register map, interrupt pin
//
// How it works
// - Reset leaves standby; conversions run only while the power mode bit is set.
// - Comparator mode: pin asserts above high threshold, releases below low threshold.
// - Wake-up mode: pin asserts above high threshold, holds until mode is left.
// - Data-ready mode: pin asserts per new result, clears on proximity read command.
// - New result during an open transaction only pulses the pin.
// - Pure SPI slave; never starts a transfer or drives data unselected.
// - First byte is direction bit plus 7-bit address, then data bytes.
// - Each chip select assertion starts fresh; first byte is a command.
// - Output changes on falling serial clock; input sampled on rising edge.
// - Single write commits on the rising edge of serial clock sixteen.
// - Chip select released before clock sixteen discards the write.
// - Holding chip select past sixteen clocks continues with incrementing addresses.
// - Extended read shifts, extended write stores, one register per eight clocks.
// - Burst from proximity register returns proximity then 24-bit frequency count.
// - Registers 0x01 to 0x05 ignore writes while active mode is selected.
// - Status: oscillator stopped, data-ready low, wake-up, comparator; low nibble zero.
// - Pin function: 000 off, 001 wake-up, 010 comparator, 100 data-ready.
// - Unread results make data-ready pulse once per period, one sensor period long.
////////////////////////////////////////////////////////////////////////////////
`include "ics_map.svh"

module ics_ctrl
   import ics_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h5a,   // Arbitrary value
   parameter int SENSOR_PERIOD_NS = 200
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // SPI pins
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe_n,
   // Measurement core
   input wire logic conv_done,
   input ics_result_t conv_result,
   output logic conv_enable,
   // Interrupt pin
   output logic interrupt_pin_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Derived constants
   localparam int PULSE_CYC =
      (SENSOR_PERIOD_NS + `ICS_CLK_PERIOD_NS - 1) / `ICS_CLK_PERIOD_NS;
   localparam logic [`ICS_PCNT_W-1:0] PULSE_LAST = `ICS_PCNT_W'(PULSE_CYC - 1);

   // Refuse pulse widths the counter cannot hold
   if (PULSE_CYC < 1 || PULSE_CYC > (1 << `ICS_PCNT_W)) begin : g_bad_period
      $error("SENSOR_PERIOD_NS out of range");
   end

   function automatic logic [`ICS_NREG-1:0][7:0] cfg_reset();
      logic [`ICS_NREG-1:0][7:0] v;
      v = '0;
      v[`ICS_A_RANGE_UPPER] = `ICS_R_RANGE_UPPER;
      v[`ICS_A_RANGE_LOWER] = `ICS_R_RANGE_LOWER;
      v[`ICS_A_LOW_FREQ] = `ICS_R_LOW_FREQ;
      v[`ICS_A_CONV_CFG] = `ICS_R_CONV_CFG;
      v[`ICS_A_RSVD_05] = `ICS_R_RSVD_05;
      v[`ICS_A_RSVD_06] = `ICS_R_RSVD_06;
      v[`ICS_A_THR_HIGH] = `ICS_R_THR_HIGH;
      v[`ICS_A_RSVD_08] = `ICS_R_RSVD_08;
      v[`ICS_A_THR_LOW] = `ICS_R_THR_LOW;
      v[`ICS_A_PIN_CFG] = `ICS_R_PIN_CFG;
      v[`ICS_A_POWER] = `ICS_R_POWER;
      return v;
   endfunction

   localparam logic [`ICS_NREG-1:0][7:0] CFG_RST = cfg_reset();

   ////////////////////////////////////////////////////////////////////////////
   // State
   ics_state_t st_reg;
   ics_state_t st_next;

   logic [`ICS_NIN-1:0] pins_in;
   logic [`ICS_NIN-1:0] lvl_new;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_start;
   logic cs_act;
   logic [7:0] byte_in;
   logic cmd_take;
   logic wr_fire;
   logic wr_ok;
   logic read_prox;
   logic conv_ev;
   logic pwr;
   logic [2:0] mode;
   logic above_hi;
   logic below_lo;
   logic [`ICS_ADDR_W-1:0] addr_inc;

   assign pins_in = {sdi, chip_select_n, sclk};
   assign pwr = st_reg.cfg[`ICS_A_POWER][`ICS_PWR_BIT];
   assign mode = st_reg.cfg[`ICS_A_PIN_CFG][`ICS_MODE_MSB:0];

   // Read mux; status and result bytes are snapshots taken at load time
   function automatic logic [7:0] read_val(ics_state_t s, logic [`ICS_ADDR_W-1:0] a);
      logic [7:0] v;
      v = `ICS_R_ZERO;
      unique case (a)
         `ICS_A_REVISION: v = REVISION;
         `ICS_A_RANGE_UPPER, `ICS_A_RANGE_LOWER, `ICS_A_LOW_FREQ, `ICS_A_CONV_CFG,
         `ICS_A_RSVD_05, `ICS_A_RSVD_06, `ICS_A_THR_HIGH, `ICS_A_RSVD_08,
         `ICS_A_THR_LOW, `ICS_A_PIN_CFG, `ICS_A_POWER: v = s.cfg[a[3:0]];
         `ICS_A_STATUS: v = {s.res.osc_stopped, ~(s.dr == ICS_DR_HOLD ||
                             s.dr == ICS_DR_PULSE), s.wake, s.comp, 4'h0};
         `ICS_A_PROX: v = s.res.prox;
         `ICS_A_FREQ_LOW: v = s.res.freq[7:0];
         `ICS_A_FREQ_MID: v = s.res.freq[15:8];
         `ICS_A_FREQ_HIGH: v = s.res.freq[23:16];
         default: v = `ICS_R_ZERO;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      st_next = st_reg;

      // Three-stage pin synchronisers; a level counts once stages two and three agree
      st_next.sync[0] = pins_in;
      st_next.sync[1] = st_reg.sync[0];
      st_next.sync[2] = st_reg.sync[1];
      for (int i = 0; i < `ICS_NIN; i++) begin
         lvl_new[i] = (st_reg.sync[1][i] == st_reg.sync[2][i]) ?
                      st_reg.sync[2][i] : st_reg.lvl[i];
      end
      st_next.lvl = lvl_new;

      sclk_rise = lvl_new[`ICS_IN_SCLK] && !st_reg.lvl[`ICS_IN_SCLK];
      sclk_fall = !lvl_new[`ICS_IN_SCLK] && st_reg.lvl[`ICS_IN_SCLK];
      cs_start = !lvl_new[`ICS_IN_CS] && st_reg.lvl[`ICS_IN_CS];
      cs_act = !lvl_new[`ICS_IN_CS];
      byte_in = {st_reg.sin[6:0], lvl_new[`ICS_IN_SDI]};
      addr_inc = st_reg.addr + `ICS_ADDR_W'(1);

      cmd_take = cs_act && sclk_rise && !st_reg.data_ph && st_reg.bcnt == `ICS_LAST_BIT;
      wr_fire = cs_act && sclk_rise && st_reg.data_ph && !st_reg.rd &&
                st_reg.bcnt == `ICS_LAST_BIT;
      wr_ok = st_reg.addr != `ICS_A_REVISION && st_reg.addr != `ICS_A_RSVD_05 &&
              st_reg.addr <= `ICS_A_POWER &&
              !(pwr && st_reg.addr <= `ICS_A_LOCK_LAST);
      read_prox = cmd_take && byte_in[`ICS_DIR_BIT] &&
                  byte_in[`ICS_ADDR_W-1:0] == `ICS_A_PROX;

      // Only acts on pin edges from the host; no self-started traffic
      if (!cs_act) begin
         st_next.data_ph = 1'b0;
         st_next.bcnt = 3'h0;
      end else if (cs_start) begin
         st_next.data_ph = 1'b0;
         st_next.rd = 1'b0;
         st_next.bcnt = 3'h0;
      end else if (sclk_rise) begin
         st_next.sin = byte_in;
         st_next.bcnt = st_reg.bcnt + 3'h1;
         if (cmd_take) begin
            st_next.data_ph = 1'b1;
            st_next.rd = byte_in[`ICS_DIR_BIT];
            st_next.addr = byte_in[`ICS_ADDR_W-1:0];
            st_next.sout = read_val(st_reg, byte_in[`ICS_ADDR_W-1:0]);
         end else if (st_reg.data_ph && st_reg.bcnt == `ICS_LAST_BIT) begin
            // Each further byte moves to the next register
            st_next.addr = addr_inc;
            if (st_reg.rd) begin
               st_next.sout = read_val(st_reg, addr_inc);
            end else if (wr_ok) begin
               // Byte complete only at clock sixteen, then every eighth clock after it; early release never gets here
               st_next.cfg[st_reg.addr[3:0]] = byte_in;
            end
         end
      end else if (sclk_fall && st_reg.data_ph && st_reg.rd) begin
         st_next.sdo = st_reg.sout[7];
         st_next.sout = {st_reg.sout[6:0], 1'b0};
      end
      st_next.sdo_oe_n = !cs_act;

      // Conversion results
      st_next.conv_en = pwr;
      conv_ev = conv_done && st_reg.conv_en;
      above_hi = conv_result.prox > st_reg.cfg[`ICS_A_THR_HIGH];
      below_lo = conv_result.prox < st_reg.cfg[`ICS_A_THR_LOW];
      if (conv_ev) begin
         st_next.res = conv_result;
         if (above_hi) begin
            st_next.comp = 1'b1;
         end else if (below_lo) begin
            st_next.comp = 1'b0;
         end
      end
      if (mode != `ICS_MODE_WAKE) begin
         st_next.wake = 1'b0;
      end else if (conv_ev && above_hi) begin
         st_next.wake = 1'b1;
      end

      // Data-ready sequencer; a new result wins over a clearing read in HOLD, the clearing read wins in GAP
      unique case (st_reg.dr)
         ICS_DR_IDLE: begin
            if (conv_ev) begin
               st_next.dr = cs_act ? ICS_DR_PULSE : ICS_DR_HOLD;
               st_next.pcnt = PULSE_LAST;
            end
         end
         ICS_DR_HOLD: begin
            if (conv_ev) begin
               // Unread result: brief release gives the host a fresh falling edge
               st_next.dr = ICS_DR_GAP;
               st_next.pcnt = PULSE_LAST;
            end else if (read_prox) begin
               st_next.dr = ICS_DR_IDLE;
            end
         end
         ICS_DR_GAP: begin
            if (read_prox) begin
               st_next.dr = ICS_DR_IDLE;
            end else if (st_reg.pcnt == '0) begin
               st_next.dr = ICS_DR_HOLD;
            end else begin
               st_next.pcnt = st_reg.pcnt - `ICS_PCNT_W'(1);
            end
         end
         ICS_DR_PULSE: begin
            if (conv_ev) begin
               st_next.pcnt = PULSE_LAST;
            end else if (st_reg.pcnt == '0) begin
               st_next.dr = ICS_DR_IDLE;
            end else begin
               st_next.pcnt = st_reg.pcnt - `ICS_PCNT_W'(1);
            end
         end
      endcase

      // Pin function select; undefined codes leave the pin idle
      unique case (mode)
         `ICS_MODE_WAKE: st_next.int_n = !st_reg.wake;
         `ICS_MODE_COMP: st_next.int_n = !st_reg.comp;
         `ICS_MODE_DATA_READY_MODE: st_next.int_n = !(st_reg.dr == ICS_DR_HOLD ||
                                           st_reg.dr == ICS_DR_PULSE);
         default: st_next.int_n = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.sync <= {3{`ICS_IN_RST}};
         st_reg.lvl <= `ICS_IN_RST;
         st_reg.cfg <= CFG_RST;
         st_reg.dr <= ICS_DR_IDLE;
         st_reg.sdo_oe_n <= 1'b1;
         st_reg.int_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sdo_out = st_reg.sdo;
   assign sdo_oe_n = st_reg.sdo_oe_n;
   assign conv_enable = st_reg.conv_en;
   assign interrupt_pin_n = st_reg.int_n;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_standby_gate: assert property (!pwr |=> !conv_enable)
      else $error("conversion enabled in standby");

   a_comp_output: assert property (
      mode == `ICS_MODE_COMP && conv_ev && above_hi |=> ##1 !interrupt_pin_n)
      else $error("comparator pin not asserted above high threshold");

   a_comp_release: assert property (
      mode == `ICS_MODE_COMP && conv_ev && below_lo && !above_hi
      |=> !st_reg.comp ##1 interrupt_pin_n)
      else $error("comparator pin not released below low threshold");

   a_wake_latch: assert property (
      st_reg.wake && mode == `ICS_MODE_WAKE && $stable(mode) |=> st_reg.wake)
      else $error("wake-up latch dropped while mode kept");

   a_data_ready_mode_clear: assert property (
      read_prox && !conv_ev && st_reg.dr == ICS_DR_HOLD
      |=> st_reg.dr == ICS_DR_IDLE)
      else $error("data-ready not cleared by proximity read");

   a_pulse_end: assert property (
      st_reg.dr == ICS_DR_PULSE && st_reg.pcnt == '0 && !conv_ev
      |=> st_reg.dr == ICS_DR_IDLE)
      else $error("data-ready pulse overran");

   a_sdo_fall_edge: assert property ($changed(sdo_out) |-> $past(sclk_fall))
      else $error("serial output changed off a falling clock");

   a_slave_drive: assert property (!sdo_oe_n |-> $past(cs_act))
      else $error("serial output driven without chip select");

   a_frame_start: assert property (cs_start |=> st_reg.bcnt == 3'h0 && !st_reg.data_ph)
      else $error("new selection did not restart command byte");

   a_lock_active: assert property (
      wr_fire && pwr && st_reg.addr == `ICS_A_RANGE_UPPER
      |=> $stable(st_reg.cfg[`ICS_A_RANGE_UPPER]))
      else $error("locked register written in active mode");

   c_write_commit: cover property (wr_fire && wr_ok);
   c_burst_freq: cover property (cmd_take && read_prox ##[1:200] st_reg.addr == `ICS_A_FREQ_HIGH);
   c_comp_assert: cover property (mode == `ICS_MODE_COMP && $fell(interrupt_pin_n));
   c_data_ready_mode_gap: cover property (st_reg.dr == ICS_DR_GAP);

endmodule // ics_ctrl

// ===== hdl/ics_map.svh
// Register offsets, field positions, reset values and timing constants
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH

`define ICS_CLK_PERIOD_NS 50
`define ICS_NREG 12
`define ICS_ADDR_W 7
`define ICS_PCNT_W 16

// Register offsets
`define ICS_A_REVISION 7'h00
`define ICS_A_RANGE_UPPER 7'h01
`define ICS_A_RANGE_LOWER 7'h02
`define ICS_A_LOW_FREQ 7'h03
`define ICS_A_CONV_CFG 7'h04
`define ICS_A_RSVD_05 7'h05
`define ICS_A_RSVD_06 7'h06
`define ICS_A_THR_HIGH 7'h07
`define ICS_A_RSVD_08 7'h08
`define ICS_A_THR_LOW 7'h09
`define ICS_A_PIN_CFG 7'h0a
`define ICS_A_POWER 7'h0b
`define ICS_A_STATUS 7'h20
`define ICS_A_RSVD_21 7'h21
`define ICS_A_PROX 7'h22
`define ICS_A_FREQ_LOW 7'h23
`define ICS_A_FREQ_MID 7'h24
`define ICS_A_FREQ_HIGH 7'h25
`define ICS_A_LOCK_LAST 7'h05

// Reset values
`define ICS_R_RANGE_UPPER 8'h0e
`define ICS_R_RANGE_LOWER 8'h14
`define ICS_R_LOW_FREQ 8'h45
`define ICS_R_CONV_CFG 8'h1b
`define ICS_R_RSVD_05 8'h01
`define ICS_R_RSVD_06 8'hff
`define ICS_R_THR_HIGH 8'hff
`define ICS_R_RSVD_08 8'h00
`define ICS_R_THR_LOW 8'h00
`define ICS_R_PIN_CFG 8'h00
`define ICS_R_POWER 8'h00
`define ICS_R_ZERO 8'h00

// Fields
`define ICS_PWR_BIT 0
`define ICS_MODE_MSB 2
`define ICS_DIR_BIT 7
`define ICS_MODE_OFF 3'h0
`define ICS_MODE_WAKE 3'h1
`define ICS_MODE_COMP 3'h2
`define ICS_MODE_DATA_READY_MODE 3'h4
`define ICS_LAST_BIT 3'h7

// Pin synchroniser lanes
`define ICS_IN_SCLK 0
`define ICS_IN_CS 1
`define ICS_IN_SDI 2
`define ICS_NIN 3
`define ICS_IN_RST 3'h2

`endif

// ===== hdl/ics_pkg.sv
// Types shared by the inductive sensor interface controller
`include "ics_map.svh"
package ics_pkg;

   typedef enum logic [1:0] {
      ICS_DR_IDLE = 2'b00,
      ICS_DR_HOLD = 2'b01,
      ICS_DR_GAP = 2'b11,
      ICS_DR_PULSE = 2'b10
   } ics_dr_t;

   typedef struct packed {
      logic osc_stopped;
      logic [7:0] prox;
      logic [23:0] freq;
   } ics_result_t;

   typedef struct packed {
      logic [2:0][`ICS_NIN-1:0] sync;
      logic [`ICS_NIN-1:0] lvl;
      logic [`ICS_NREG-1:0][7:0] cfg;
      ics_result_t res;
      logic comp;
      logic wake;
      ics_dr_t dr;
      logic [`ICS_PCNT_W-1:0] pcnt;
      logic data_ph;
      logic rd;
      logic [`ICS_ADDR_W-1:0] addr;
      logic [2:0] bcnt;
      logic [7:0] sin;
      logic [7:0] sout;
      logic sdo;
      logic sdo_oe_n;
      logic int_n;
      logic conv_en;
   } ics_state_t;

endpackage
